// [core/wdog_pkg.sv]
// constants shared by the watchdog block: register map, field layout, service bytes, timing
// assumes a 250 MHz core clock; one machine cycle is a fixed number of core clocks
package wdog_pkg;
    // register indices; the lite-bus byte address is four times the index
    localparam logic [7:0] ADDR_SERVICE   = 8'ha6;
    localparam logic [7:0] ADDR_SELECT    = 8'ha7;
    localparam logic [7:0] ADDR_STATUS    = 8'ha8;
    localparam logic [7:0] ADDR_POWER     = 8'hac;
    // service sequence bytes
    localparam logic [7:0] SERVICE_FIRST  = 8'h1e;
    localparam logic [7:0] SERVICE_SECOND = 8'he1;
    // select register layout
    localparam int         SEL_WIDTH      = 3;
    localparam logic [2:0] SEL_RESET      = 3'h0;
    // power control bits
    localparam int         PWR_IDLE_BIT   = 0;
    localparam int         PWR_DOWN_BIT   = 1;
    // counter sizes
    localparam int         COUNT_WIDTH    = 14;
    localparam int         PRESCALE_WIDTH = 7;
    localparam int         MCYCLE_OSC     = 12;
    localparam int         PULSE_OSC      = 96;
    // axi responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
endpackage

// [core/wdog_sync.sv]
// three-stage synchroniser for a pin level; output changes once stages two and three agree
// assumes the pin is asynchronous to the core clock
module wdog_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_dout;

    always_comb begin
        next_stage = {stage[1:0], din};
        next_dout  = (stage[2] == stage[1]) ? stage[2] : dout;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= {3{INIT}};
            dout  <= INIT;
        end else begin
            stage <= next_stage;
            dout  <= next_dout;
        end
    end
endmodule

// [core/wdog_top.sv]
// hardware watchdog with timeout prescaler, power-down and idle handling, axi4-lite slave
// assumes one core clock stands for the oscillator; power-down gates the count, not the clock
module wdog_top #(
    parameter int MCYCLE = wdog_pkg::MCYCLE_OSC,
    parameter int PULSE  = wdog_pkg::PULSE_OSC
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // axi4-lite write
    input  wire logic [9:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [9:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // wake interrupt pin, active low level
    input  wire logic        WAKE_INT_N,
    // reset pulse out and wake interrupt taken
    output logic             WDT_RESET,
    output logic             WAKE_TAKEN
);
    typedef enum logic [1:0] {
        RUN   = 2'b00,
        IDLE  = 2'b01,
        DOWN  = 2'b10,
        WAKE  = 2'b11
    } pmode_t;

    localparam int TOTAL_W = wdog_pkg::COUNT_WIDTH + wdog_pkg::PRESCALE_WIDTH;

    logic                            wake_n;
    pmode_t                          mode, next_mode;
    logic                            enabled, next_enabled, armed, next_armed;
    logic [wdog_pkg::SEL_WIDTH-1:0]  sel, next_sel;
    logic [TOTAL_W-1:0]              count, next_count;
    logic [7:0]                      mdiv, next_mdiv, pulse, next_pulse;
    logic                            wake_en, next_wake_en, taken, next_taken;
    logic                            aw_held, next_aw_held, w_held, next_w_held;
    logic [9:0]                      awaddr, next_awaddr;
    logic [7:0]                      wbyte, next_wbyte;
    logic                            wbyte_ok, next_wbyte_ok;
    logic                            bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0]                      bresp, next_bresp, rresp, next_rresp;
    logic [31:0]                     rdata, next_rdata;
    logic                            wr_fire, mtick, ticking, overflow;
    logic [TOTAL_W-1:0]              limit;

    wdog_sync #(.INIT(1'b1)) u_wake (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .din   (WAKE_INT_N),
        .dout  (wake_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: address and data taken in either order, one write at a time

    assign S_AXI_AWREADY = !aw_held && !bvalid;
    assign S_AXI_WREADY  = !w_held && !bvalid;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_BVALID  = bvalid;
    assign S_AXI_BRESP   = bresp;
    assign S_AXI_RVALID  = rvalid;
    assign S_AXI_RDATA   = rdata;
    assign S_AXI_RRESP   = rresp;
    assign wr_fire       = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_awaddr   = awaddr;
        next_wbyte    = wbyte;
        next_wbyte_ok = wbyte_ok;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_rvalid   = rvalid;
        next_rdata    = rdata;
        next_rresp    = rresp;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_held = 1'b1;
            next_awaddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_held   = 1'b1;
            next_wbyte    = S_AXI_WDATA[7:0];
            next_wbyte_ok = S_AXI_WSTRB[0];
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            unique case (awaddr[9:2])
                wdog_pkg::ADDR_SERVICE,
                wdog_pkg::ADDR_SELECT,
                wdog_pkg::ADDR_POWER:  next_bresp = wdog_pkg::RESP_OKAY;
                default:               next_bresp = wdog_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_rvalid = 1'b1;
            next_rresp  = wdog_pkg::RESP_OKAY;
            next_rdata  = '0;
            unique case (S_AXI_ARADDR[9:2])
                // upper select bits undefined: they read zero here
                wdog_pkg::ADDR_SELECT: next_rdata[2:0] = sel;
                wdog_pkg::ADDR_STATUS: next_rdata[3:0] = {armed, enabled, mode};
                wdog_pkg::ADDR_POWER:  next_rdata[1:0] = {mode == DOWN, mode == IDLE};
                // service port is write-only, counter never visible
                wdog_pkg::ADDR_SERVICE: next_rdata = '0;
                default:               next_rresp = wdog_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog core

    // total width covers 14-bit counter times the 7-bit prescale
    assign limit    = TOTAL_W'((((1 << wdog_pkg::COUNT_WIDTH) - 1) << sel) + (1 << sel) - 1);
    // oscillator stops in power-down and in wake until pin rises
    assign ticking  = (mode == RUN) || (mode == IDLE);
    assign mtick    = ticking && (mdiv == 8'(MCYCLE - 1));
    // select doubles the span per code, 000 counts to 3fff and overflows on the next tick, a base of 4000 cycles
    assign overflow = enabled && mtick && (count >= limit);

    always_comb begin
        next_mode     = mode;
        next_enabled  = enabled;
        next_armed    = armed;
        next_sel      = sel;
        next_count    = count;
        next_mdiv     = mdiv;
        next_pulse    = (pulse != 8'h00) ? pulse - 8'h01 : 8'h00;
        next_wake_en  = wake_en;
        next_taken    = 1'b0;
        if (ticking) begin
            next_mdiv = mtick ? 8'h00 : mdiv + 8'h01;
        end
        if (enabled && mtick) begin
            next_count = count + TOTAL_W'(1);
        end
        if (wr_fire && wbyte_ok) begin
            unique case (awaddr[9:2])
                wdog_pkg::ADDR_SERVICE: begin
                    // 1e arms, e1 directly after enables or clears
                    if (wbyte == wdog_pkg::SERVICE_FIRST) begin
                        next_armed = 1'b1;
                    end else begin
                        next_armed = 1'b0;
                        if (armed && wbyte == wdog_pkg::SERVICE_SECOND) begin
                            next_enabled = 1'b1;
                            next_count   = '0;
                        end
                    end
                end
                wdog_pkg::ADDR_SELECT: next_sel = wbyte[wdog_pkg::SEL_WIDTH-1:0];
                wdog_pkg::ADDR_POWER: begin
                    // the write that enters power-down also enables the low wake level that ends it
                    next_wake_en = wbyte[wdog_pkg::PWR_DOWN_BIT];
                    if (wbyte[wdog_pkg::PWR_DOWN_BIT]) begin
                        next_mode = DOWN;
                    end else if (wbyte[wdog_pkg::PWR_IDLE_BIT]) begin
                        next_mode = IDLE;
                    end
                end
                default: ;
            endcase
        end
        unique case (mode)
            DOWN: if (wake_en && !wake_n) next_mode = WAKE;
            WAKE: if (wake_n) begin
                next_mode  = RUN;
                next_taken = 1'b1;
            end
            IDLE: if (!wake_n) next_mode = RUN;
            RUN:  ;
        endcase
        if (overflow) begin
            // overflow acts like reset: disabled, count cleared
            next_pulse   = 8'(PULSE);
            next_enabled = 1'b0;
            next_armed   = 1'b0;
            next_count   = '0;
            next_sel     = wdog_pkg::SEL_RESET;
            next_mode    = RUN;
        end
    end

    assign WDT_RESET  = (pulse != 8'h00);
    assign WAKE_TAKEN = taken;

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode     <= RUN;
            enabled  <= 1'b0;
            armed    <= 1'b0;
            sel      <= wdog_pkg::SEL_RESET;
            count    <= '0;
            mdiv     <= 8'h00;
            pulse    <= 8'h00;
            wake_en  <= 1'b0;
            taken    <= 1'b0;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awaddr   <= 10'h000;
            wbyte    <= 8'h00;
            wbyte_ok <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
            rvalid   <= 1'b0;
            rdata    <= 32'h0;
            rresp    <= 2'h0;
        end else begin
            mode     <= next_mode;
            enabled  <= next_enabled;
            armed    <= next_armed;
            sel      <= next_sel;
            count    <= next_count;
            mdiv     <= next_mdiv;
            pulse    <= next_pulse;
            wake_en  <= next_wake_en;
            taken    <= next_taken;
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            awaddr   <= next_awaddr;
            wbyte    <= next_wbyte;
            wbyte_ok <= next_wbyte_ok;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    property p_sel_reset; $rose(RST_N) |-> (sel == 3'h0); endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("select not zero after reset");
    property p_down_hold; (mode == DOWN) ##1 (mode == DOWN) |-> $stable(count); endproperty
    a_down_hold: assert property (p_down_hold) else $error("counter moved in power-down");
    property p_down_exit;
        (mode == DOWN) && !(wake_en && !wake_n) && !overflow |=> (mode == DOWN); endproperty
    a_down_exit: assert property (p_down_exit) else $error("power-down left without cause");
    property p_ovf_off; overflow |=> !enabled && (count == '0); endproperty
    a_ovf_off: assert property (p_ovf_off) else $error("watchdog not reset by overflow");
    sequence s_wake_rise; (mode == WAKE) ##1 (mode == RUN); endsequence
    property p_wake_taken; s_wake_rise |-> WAKE_TAKEN; endproperty
    a_wake_taken: assert property (p_wake_taken) else $error("wake interrupt not taken");
    property p_wake_stop;
        (mode == WAKE) && !wake_n |=> $stable(count) && (mode == WAKE); endproperty
    a_wake_stop: assert property (p_wake_stop) else $error("counter ran with wake pin low");
    property p_idle_count; (mode == IDLE) && enabled && mtick && !overflow && !wr_fire
        |=> count == $past(count) + 1; endproperty
    a_idle_count: assert property (p_idle_count) else $error("no count in idle");
    property p_pulse_len; overflow |=> WDT_RESET [*8]; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short");
    property p_pulse_end; overflow |-> ##[1:96] (pulse == 8'h01); endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("reset pulse length wrong");
    property p_no_enable; $rose(enabled) |-> $past(armed); endproperty
    a_no_enable: assert property (p_no_enable) else $error("enabled without 1e first");
endmodule

// [test/watchdog_prescaler_power_modes_tb.sv]
// self-checking bench for the watchdog block: lite-bus registers, timeouts, idle and power-down
// assumes wdog_top with a one-clock machine cycle; the bench drives every port itself
module watchdog_prescaler_power_modes_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PULSE_LEN = 96;

    logic        REF_CLK, RST_N, WAKE_INT_N, WDT_RESET, WAKE_TAKEN;
    logic [9:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
    logic        S_AXI_RVALID, S_AXI_RREADY;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, seed, rd, v;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
    int          err_total, checks_done, cycles, t, n0, n1, n, hits;

    wdog_top #(.MCYCLE(1), .PULSE(PULSE_LEN)) wdog_top_i (
        .REF_CLK(REF_CLK), .RST_N(RST_N),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
        .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
        .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
        .WAKE_INT_N(WAKE_INT_N), .WDT_RESET(WDT_RESET), .WAKE_TAKEN(WAKE_TAKEN)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    always #2 REF_CLK = ~REF_CLK;

    // three timeouts, a serviced idle stretch and a long power-down hold, about 93k cycles
    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // ready is decided at the falling edge, so the taking edge is the next rising one
    // a is the register index; the bus carries four times it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic ah, wh, bh;
        bh = 1'b0;
        @(posedge REF_CLK);
        S_AXI_AWADDR  <= {a, 2'b00};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA   <= d;
        S_AXI_WSTRB   <= s;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        while (!bh) begin
            @(negedge REF_CLK);
            ah = S_AXI_AWVALID & S_AXI_AWREADY;
            wh = S_AXI_WVALID & S_AXI_WREADY;
            bh = S_AXI_BVALID & S_AXI_BREADY;
            r  = S_AXI_BRESP;
            @(posedge REF_CLK);
            if (ah) S_AXI_AWVALID <= 1'b0;
            if (wh) S_AXI_WVALID <= 1'b0;
            if (bh) S_AXI_BREADY <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        rh = 1'b0;
        @(posedge REF_CLK);
        S_AXI_ARADDR  <= {a, 2'b00};
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        while (!rh) begin
            @(negedge REF_CLK);
            ah = S_AXI_ARVALID & S_AXI_ARREADY;
            rh = S_AXI_RVALID & S_AXI_RREADY;
            d  = S_AXI_RDATA;
            r  = S_AXI_RRESP;
            @(posedge REF_CLK);
            if (ah) S_AXI_ARVALID <= 1'b0;
            if (rh) S_AXI_RREADY <= 1'b0;
        end
    endtask

    task automatic service();
        axi_wr(wdog_pkg::ADDR_SERVICE, {24'h0, wdog_pkg::SERVICE_FIRST}, 4'hf, rsp);
        axi_wr(wdog_pkg::ADDR_SERVICE, {24'h0, wdog_pkg::SERVICE_SECOND}, 4'hf, rsp);
        t = cycles;
    endtask

    task automatic watch(input int k);
        hits = 0;
        repeat (k) begin
            @(negedge REF_CLK);
            if (WDT_RESET !== 1'b0 || WAKE_TAKEN !== 1'b0) hits++;
        end
    endtask

    // returns cycles from the last service to the reset pulse, then measures its width
    task automatic wait_reset(output int m);
        int w;
        w = 0;
        @(negedge REF_CLK);
        while (WDT_RESET !== 1'b1) @(negedge REF_CLK);
        m = cycles - t;
        while (WDT_RESET === 1'b1) begin
            @(negedge REF_CLK);
            w++;
        end
        check("reset pulse width", 32'(w), 32'(PULSE_LEN));
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {REF_CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
        {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
        S_AXI_WDATA = 32'h0;
        S_AXI_WSTRB = 4'h0;
        WAKE_INT_N  = 1'b1;
        seed        = 32'd75225;
        {err_total, checks_done, cycles} = '0;
        repeat (8) @(posedge REF_CLK);
        RST_N <= 1'b1;
        axi_rd(wdog_pkg::ADDR_SELECT, rd, rsp);
        check("select after reset", {29'h0, rd[2:0]}, 32'h0);
        axi_rd(wdog_pkg::ADDR_STATUS, rd, rsp);
        check("enabled after reset", {31'h0, rd[2]}, 32'h0);
        axi_rd(wdog_pkg::ADDR_SERVICE, rd, rsp);
        check("service readback", rd, 32'h0);
        repeat (6) begin
            v = xs();
            axi_wr(wdog_pkg::ADDR_SELECT, v, 4'hf, rsp);
            axi_rd(wdog_pkg::ADDR_SELECT, rd, rsp);
            check("select readback", rd, {29'h0, v[2:0]});
        end
        // a write with lane zero off must leave the field alone
        axi_wr(wdog_pkg::ADDR_SELECT, ~v, 4'he, rsp);
        axi_rd(wdog_pkg::ADDR_SELECT, rd, rsp);
        check("select masked write", rd, {29'h0, v[2:0]});
        axi_rd(8'h10, rd, rsp);
        check("unmapped read resp", {30'h0, rsp}, {30'h0, wdog_pkg::RESP_SLVERR});
        axi_wr(8'h10, 32'h0, 4'hf, rsp);
        check("unmapped write resp", {30'h0, rsp}, {30'h0, wdog_pkg::RESP_SLVERR});
        // a foreign byte between the two halves breaks the sequence
        axi_wr(wdog_pkg::ADDR_SERVICE, {24'h0, wdog_pkg::SERVICE_FIRST}, 4'hf, rsp);
        axi_wr(wdog_pkg::ADDR_SERVICE, 32'h55, 4'hf, rsp);
        axi_wr(wdog_pkg::ADDR_SERVICE, {24'h0, wdog_pkg::SERVICE_SECOND}, 4'hf, rsp);
        axi_rd(wdog_pkg::ADDR_STATUS, rd, rsp);
        check("broken sequence enables", {31'h0, rd[2]}, 32'h0);
        axi_wr(wdog_pkg::ADDR_SELECT, 32'h0, 4'hf, rsp);
        service();
        axi_wr(wdog_pkg::ADDR_POWER, 32'h1, 4'hf, rsp);
        axi_rd(wdog_pkg::ADDR_STATUS, rd, rsp);
        check("idle mode", {30'h0, rd[1:0]}, 32'h1);
        // idle for 8000 cycles, well inside the timeout, then service and write idle again
        watch(8000);
        check("reset during serviced idle", 32'(hits), 32'h0);
        service();
        axi_wr(wdog_pkg::ADDR_POWER, 32'h1, 4'hf, rsp);
        wait_reset(n0);
        check("idle timeout near 3fff", 32'(n0 > 16370 && n0 < 16400), 32'h1);
        axi_rd(wdog_pkg::ADDR_STATUS, rd, rsp);
        check("enabled after overflow", {31'h0, rd[2]}, 32'h0);
        axi_wr(wdog_pkg::ADDR_SELECT, 32'h1, 4'hf, rsp);
        service();
        wait_reset(n1);
        check("select one doubles", 32'(n1 - n0), 32'd16384);
        axi_wr(wdog_pkg::ADDR_SELECT, 32'h0, 4'hf, rsp);
        service();
        axi_wr(wdog_pkg::ADDR_POWER, 32'h2, 4'hf, rsp);
        axi_rd(wdog_pkg::ADDR_STATUS, rd, rsp);
        check("power-down mode", {30'h0, rd[1:0]}, 32'h2);
        // longer than a full timeout: a running count would have fired
        watch(17000);
        check("activity in power-down", 32'(hits), 32'h0);
        @(posedge REF_CLK);
        WAKE_INT_N <= 1'b0;
        watch(2000);
        check("activity while pin low", 32'(hits), 32'h0);
        axi_rd(wdog_pkg::ADDR_STATUS, rd, rsp);
        check("wake mode", {30'h0, rd[1:0]}, 32'h3);
        @(posedge REF_CLK);
        WAKE_INT_N <= 1'b1;
        t = cycles;
        watch(12);
        check("wake taken pulses", 32'(hits), 32'h1);
        axi_rd(wdog_pkg::ADDR_STATUS, rd, rsp);
        check("run after wake", {30'h0, rd[1:0]}, 32'h0);
        // the wake handler services the watchdog before anything else
        service();
        wait_reset(n);
        check("count resumes after wake", 32'(n > 16250 && n < 16400), 32'h1);
        results();
    end
endmodule
